// >>> design/msl_map.vh
/*
  Constants of the multi-unit synchronization link: roles,
  message codes and timing counts.
  Assumes inclusion by the Verilog-2005 design files and the SystemVerilog bench files.
*/
`ifndef MSL_MAP_VH
`define MSL_MAP_VH

// Roles
`define MSL_ROLE_ISOLATED   2'h0
`define MSL_ROLE_LEADER     2'h1
`define MSL_ROLE_FOLLOWER   2'h2

// Message codes, upper nibble of a link word
`define MSL_MSG_IDLE        4'h0
`define MSL_MSG_TICK        4'h1
`define MSL_MSG_PING        4'h2
`define MSL_MSG_PONG        4'h3
`define MSL_MSG_TRIG        4'h4
`define MSL_MSG_START       4'h5
`define MSL_MSG_STOP        4'h6
`define MSL_MSG_PAUSE       4'h7
`define MSL_MSG_MANTRIG     4'h8
`define MSL_MSG_CALCTRIG    4'h9
`define MSL_MSG_DELAY       4'hA
`define MSL_MSG_FIRST       4'hB

// Timing
`define MSL_TICK_PERIOD     16'h0064
`define MSL_PING_PERIOD     16'h03E8
`define MSL_MAX_DELAY       16'h0400
`define MSL_ACT_LEAD        16'h0400

`endif

// >>> design/msl_delay_line.v
/*
  Delay line: holds a WIDTH-bit event vector and releases it a
  programmable number of cycles later, for cable delay alignment.
  Assumes the delay stays below the line depth.
*/
`timescale 1ns/1ps

module msl_delay_line #(
  parameter WIDTH = 8,
  parameter DEPTH = 1024,
  parameter AW    = 10
) (
  input  wire             clk_i,
  input  wire             sys_rst_i,
  input  wire [WIDTH-1:0] din_i,
  input  wire [AW-1:0]    delay_i,
  output reg  [WIDTH-1:0] dout_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  wire [AW-1:0]   rd_ptr = wr_ptr_ff - delay_i;

  always @(posedge clk_i) begin
    mem[wr_ptr_ff] <= din_i;
    if (sys_rst_i) begin
      wr_ptr_ff <= {AW{1'b0}};
      dout_o    <= {WIDTH{1'b0}};
    end else begin
      wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      dout_o    <= (delay_i == {AW{1'b0}}) ? din_i : mem[rd_ptr];
    end
  end

endmodule // msl_delay_line

// >>> design/msl_sync_link.v
/*
  Multi-unit synchronization link: role handling, link status indicators,
  sample tick lock, cable delay measurement and event exchange.
  Assumes a serial transceiver outside that delivers aligned 16-bit words
  with status flags, and a peer block of the same design on the far side.
*/
// Overview of operation
// - Three roles: leader, follower, isolated
// - Isolated role sends and heeds nothing
// - Direct link pairs one leader, one follower
// - Two indicators: signal and data
// - No signal nor characters: both off
// - Alignment only lights signal; data both
// - First sample taken same instant everywhere
// - Follower sample tick locks to leader
// - Channel triggers exchanged both ways synchronously
// - Measure and compensate cable delay
// - Start and pause distributed synchronously
// - Stop is distributed without sample alignment
// - Manual trigger fires all units together
// - Calculated channel triggers also exchanged
// - Standard and extended schemes both supported
// - Direct two-unit link uses extended scheme
// - Follower ignores own time source
`timescale 1ns/1ps
`include "msl_map.vh"

module msl_sync_link #(
  parameter TICK_PERIOD = 100,
  parameter PING_PERIOD = 1000,
  parameter DLY_AW      = 10
) (
  input  wire        clk_i,
  input  wire        sys_rst_i,
  input  wire [1:0]  role_i,
  input  wire        direct_link_i,
  input  wire        ext_mode_i,
  input  wire        own_time_src_i,
  input  wire        rx_sig_det_i,
  input  wire        rx_align_i,
  input  wire        rx_valid_i,
  input  wire [15:0] rx_word_i,
  input  wire        chan_trig_i,
  input  wire        calc_trig_i,
  input  wire        man_trig_i,
  input  wire        rec_start_i,
  input  wire        rec_stop_i,
  input  wire        rec_pause_i,
  output reg  [15:0] tx_word_o,
  output reg         tx_en_o,
  output reg         led_sig_o,
  output reg         led_data_o,
  output reg         sample_tick_o,
  output reg         first_sample_o,
  output reg         trig_o,
  output reg         rec_start_o,
  output reg         rec_stop_o,
  output reg         rec_pause_o,
  output reg         time_src_o,
  output reg  [15:0] cable_delay_o,
  output wire        ext_active_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [2:0]  st_meta_ff;
  reg [2:0]  st_ff;
  reg [15:0] word_ff;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_meta_ff <= 3'h0;
      st_ff      <= 3'h0;
      word_ff    <= 16'h0000;
    end else begin
      st_meta_ff <= {rx_valid_i, rx_align_i, rx_sig_det_i};
      st_ff      <= st_meta_ff;
      word_ff    <= rx_word_i;
    end
  end
  wire sig_det = st_ff[0];
  wire aligned = st_ff[1];
  wire valid   = st_ff[2];

  // ----------------------------------------------------------------
  // Role decode
  // ----------------------------------------------------------------
  // role select
  wire is_leader   = (role_i == `MSL_ROLE_LEADER);
  wire is_follower = (role_i == `MSL_ROLE_FOLLOWER);
  wire active      = is_leader | is_follower;
  assign ext_active_o = active & (ext_mode_i | direct_link_i);
  wire link_up     = active & sig_det & aligned & valid;
  wire [3:0]  rx_op  = word_ff[15:12];
  wire [11:0] rx_arg = word_ff[11:0];
  wire rx_ok = link_up;

  // ----------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      led_sig_o  <= 1'b0;
      led_data_o <= 1'b0;
    end else begin
      led_sig_o  <= sig_det & (aligned | valid);
      led_data_o <= sig_det & aligned & valid;
    end
  end

  // ----------------------------------------------------------------
  // Sample tick and cable delay
  // ----------------------------------------------------------------
  reg [15:0] tick_cnt_ff;
  reg [15:0] ping_cnt_ff;
  reg [15:0] rtt_cnt_ff;
  reg        ping_wait_ff;
  reg [15:0] nxt_delay;
  wire rx_tick = rx_ok & (rx_op == `MSL_MSG_TICK);
  wire rx_pong = rx_ok & (rx_op == `MSL_MSG_PONG);
  wire rx_dly  = rx_ok & (rx_op == `MSL_MSG_DELAY);
  wire lead_tick = (tick_cnt_ff == TICK_PERIOD - 1);
  // Event words may not be lost, so a due ping waits for a free slot
  wire ev_tx     = chan_trig_i | (ext_active_o & (man_trig_i | calc_trig_i | rec_start_i |
                   rec_pause_i | rec_stop_i));
  wire ping_due  = is_leader & link_up & !ping_wait_ff & !lead_tick & !ev_tx &
                   (ping_cnt_ff >= PING_PERIOD - 1);

  always @* begin
    nxt_delay = cable_delay_o;
    if (is_leader & rx_pong)
      nxt_delay = {1'b0, rtt_cnt_ff[15:1]};
    else if (is_follower & rx_dly)
      nxt_delay = {4'h0, rx_arg};
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      tick_cnt_ff   <= 16'h0000;
      ping_cnt_ff   <= 16'h0000;
      rtt_cnt_ff    <= 16'h0000;
      ping_wait_ff  <= 1'b0;
      cable_delay_o <= 16'h0000;
      sample_tick_o <= 1'b0;
    end else begin
      if (is_follower & rx_tick)
        tick_cnt_ff <= 16'h0000;
      else if (lead_tick)
        tick_cnt_ff <= 16'h0000;
      else
        tick_cnt_ff <= tick_cnt_ff + 16'h0001;
      sample_tick_o <= lead_tick;
      if (ping_due | !link_up)
        ping_cnt_ff <= 16'h0000;
      else if (ping_cnt_ff < PING_PERIOD - 1)
        ping_cnt_ff <= ping_cnt_ff + 16'h0001;
      if (ping_due) begin
        ping_wait_ff <= 1'b1;
        rtt_cnt_ff   <= 16'h0000;
      end else if (rx_pong | !link_up) begin
        ping_wait_ff <= 1'b0;
      end else if (ping_wait_ff) begin
        rtt_cnt_ff <= rtt_cnt_ff + 16'h0001;
      end
      cable_delay_o <= link_up ? nxt_delay : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Event exchange with delay alignment
  // ----------------------------------------------------------------
  // Local events other than stop wait until the far copy has travelled the cable
  wire       first_go;
  reg        started_ff;
  reg        start_pend_ff;
  wire [5:0] loc_dly;
  assign first_go = start_pend_ff & lead_tick;
  wire [5:0] loc_ev = {first_go, calc_trig_i, man_trig_i, rec_pause_i,
                       rec_start_i, chan_trig_i};

  msl_delay_line #(
    .WIDTH (6),
    .DEPTH (1 << DLY_AW),
    .AW    (DLY_AW)
  ) u_dly (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .din_i     (loc_ev),
    .delay_i   (cable_delay_o[DLY_AW-1:0]),
    .dout_o    (loc_dly)
  );

  wire ext = ext_active_o;
  wire rx_trig  = rx_ok & (rx_op == `MSL_MSG_TRIG);
  wire rx_start = rx_ok & ext & (rx_op == `MSL_MSG_START);
  wire rx_stop  = rx_ok & ext & (rx_op == `MSL_MSG_STOP);
  wire rx_pause = rx_ok & ext & (rx_op == `MSL_MSG_PAUSE);
  wire rx_man   = rx_ok & ext & (rx_op == `MSL_MSG_MANTRIG);
  wire rx_calc  = rx_ok & ext & (rx_op == `MSL_MSG_CALCTRIG);
  wire rx_first = rx_ok & (rx_op == `MSL_MSG_FIRST);

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      started_ff     <= 1'b0;
      start_pend_ff  <= 1'b0;
      first_sample_o <= 1'b0;
      trig_o         <= 1'b0;
      rec_start_o    <= 1'b0;
      rec_stop_o     <= 1'b0;
      rec_pause_o    <= 1'b0;
    end else begin
      if (rec_start_i & !started_ff)
        start_pend_ff <= 1'b1;
      else if (first_go)
        start_pend_ff <= 1'b0;
      if (first_go)
        started_ff <= 1'b1;
      else if (rec_stop_i)
        started_ff <= 1'b0;
      first_sample_o <= loc_dly[5] | (is_follower & rx_first);
      trig_o <= loc_dly[0] | rx_trig | (ext & (loc_dly[3] | loc_dly[4] | rx_man | rx_calc));
      rec_start_o <= (ext & loc_dly[1]) | rx_start;
      rec_pause_o <= (ext & loc_dly[2]) | rx_pause;
      rec_stop_o  <= rec_stop_i | rx_stop;
    end
  end

  // ----------------------------------------------------------------
  // Transmit
  // ----------------------------------------------------------------
  reg [15:0] nxt_tx;
  always @* begin
    nxt_tx = {`MSL_MSG_IDLE, 12'h000};
    if (is_follower & rx_ok & (rx_op == `MSL_MSG_PING))
      nxt_tx = {`MSL_MSG_PONG, 12'h000};
    else if (is_leader & first_go)
      nxt_tx = {`MSL_MSG_FIRST, 12'h000};
    else if (is_leader & lead_tick)
      nxt_tx = {`MSL_MSG_TICK, 12'h000};
    else if (ping_due)
      nxt_tx = {`MSL_MSG_PING, 12'h000};
    else if (chan_trig_i)
      nxt_tx = {`MSL_MSG_TRIG, 12'h000};
    else if (ext & man_trig_i)
      nxt_tx = {`MSL_MSG_MANTRIG, 12'h000};
    else if (ext & calc_trig_i)
      nxt_tx = {`MSL_MSG_CALCTRIG, 12'h000};
    else if (ext & rec_start_i)
      nxt_tx = {`MSL_MSG_START, 12'h000};
    else if (ext & rec_pause_i)
      nxt_tx = {`MSL_MSG_PAUSE, 12'h000};
    else if (ext & rec_stop_i)
      nxt_tx = {`MSL_MSG_STOP, 12'h000};
    else if (is_leader & rx_pong)
      nxt_tx = {`MSL_MSG_DELAY, nxt_delay[11:0]};
  end

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_word_o  <= 16'h0000;
      tx_en_o    <= 1'b0;
      time_src_o <= 1'b0;
    end else begin
      tx_en_o    <= active;
      tx_word_o  <= active ? nxt_tx : 16'h0000;
      time_src_o <= is_follower ? 1'b0 : own_time_src_i;
    end
  end

endmodule // msl_sync_link

// >>> bench/msl_peer_model.sv
/* Peer link model: answers pings after a set lag, sends words on request.
   Assumes bench link level 0 none, 1 alignment, 2 valid data. */
`timescale 1ns/1ps
`include "msl_map.vh"
module msl_peer_model (
  input  wire        clk_i,
  input  wire [15:0] tx_word_i,
  input  wire [1:0]  lvl_i,
  input  wire [7:0]  lag_i,
  input  wire        snd_i,
  input  wire [15:0] snd_word_i,
  output wire        sig_o,
  output wire        align_o,
  output wire        valid_o,
  output reg  [15:0] word_o
);
  reg [7:0]  cnt_ff = 8'h00;
  reg [11:0] arg_ff = 12'h000;
  assign sig_o   = (lvl_i != 2'h0);
  assign align_o = (lvl_i != 2'h0);
  assign valid_o = (lvl_i == 2'h2);
  initial word_o = 16'h0000;
  always @(posedge clk_i) begin
    // A bench word holds the echo back one cycle instead of losing it
    if (cnt_ff != 8'h01 || !snd_i)
      cnt_ff <= (cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00;
    if (tx_word_i[15:12] == `MSL_MSG_PING) begin
      cnt_ff <= lag_i + 8'h01;
      arg_ff <= tx_word_i[11:0];
    end
    // Line without valid data toggles so stale words never look good
    if (lvl_i != 2'h2) word_o <= ~word_o;
    else if (snd_i) word_o <= snd_word_i;
    else if (cnt_ff == 8'h01) word_o <= {`MSL_MSG_PONG, arg_ff};
    else word_o <= 16'h0000;
  end
endmodule // msl_peer_model

// >>> bench/msl_sync_link_checker.sv
/* Port checker for msl_sync_link.
   Assumes the bind below attaches it to every instance. */
`timescale 1ns/1ps
`include "msl_map.vh"
module msl_sync_link_checker (
  input wire        clk_i,
  input wire        sys_rst_i,
  input wire [1:0]  role_i,
  input wire        direct_link_i,
  input wire        ext_mode_i,
  input wire        own_time_src_i,
  input wire        rx_sig_det_i,
  input wire        rx_align_i,
  input wire        rx_valid_i,
  input wire [15:0] tx_word_o,
  input wire        tx_en_o,
  input wire        led_sig_o,
  input wire        led_data_o,
  input wire        time_src_o,
  input wire        ext_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_ISO_TX: assert property (role_i == `MSL_ROLE_ISOLATED
    |=> !tx_en_o && tx_word_o == 16'h0000) else $error("isolated sends");
  AST_TX_EN: assert property (!sys_rst_i && (role_i == `MSL_ROLE_LEADER
    || role_i == `MSL_ROLE_FOLLOWER) |=> tx_en_o) else $error("role silent");
  AST_LED_OFF: assert property ((!rx_sig_det_i) [*4]
    |-> !led_sig_o && !led_data_o) else $error("leds lit");
  AST_LED_SIG: assert property ((rx_sig_det_i && rx_align_i && !rx_valid_i) [*4]
    |-> led_sig_o && !led_data_o) else $error("align leds");
  AST_LED_BOTH: assert property ((rx_sig_det_i && rx_align_i && rx_valid_i) [*4]
    |-> led_sig_o && led_data_o) else $error("data leds");
  AST_TS_FOL: assert property (role_i == `MSL_ROLE_FOLLOWER |=> !time_src_o)
    else $error("follower time source");
  AST_TS_LEAD: assert property (!sys_rst_i && role_i == `MSL_ROLE_LEADER
    |=> time_src_o == $past(own_time_src_i)) else $error("leader time source");
  AST_EXT_OFF: assert property (role_i == `MSL_ROLE_ISOLATED
    || !(ext_mode_i || direct_link_i) |-> !ext_active_o) else $error("scheme");
  cover property (led_sig_o && led_data_o);
  cover property (ext_active_o);
  cover property (role_i == `MSL_ROLE_FOLLOWER ##1 !time_src_o);
endmodule // msl_sync_link_checker
bind msl_sync_link msl_sync_link_checker u_msl_sync_link_checker (.*);

// >>> bench/tb_msl_sync_link.sv
/* Self-checking bench for msl_sync_link against a peer model.
   Assumes the peer model and checker are compiled first. */
`timescale 1ns/1ps
`include "msl_map.vh"
module tb_msl_sync_link;
  localparam [19:0] OPS = {`MSL_MSG_STOP, `MSL_MSG_PAUSE, `MSL_MSG_MANTRIG,
                           `MSL_MSG_CALCTRIG, `MSL_MSG_TRIG};
  reg         clk_i     = 1'b0;
  reg         sys_rst_i = 1'b1;
  reg  [1:0]  role      = `MSL_ROLE_LEADER;
  reg         dlink     = 1'b0;
  reg         xm        = 1'b0;
  reg         tsrc      = 1'b1;
  wire        ts_o, st_o;
  reg  [5:0]  ev        = 6'h00;
  reg  [1:0]  lvl       = 2'h0;
  reg  [7:0]  lag       = 8'h00;
  reg         snd       = 1'b0;
  reg  [15:0] pk        = 16'h0000;
  reg  [15:0] d0;
  reg         hit;
  wire        sd, al, vd, tx_en, l_sig, l_dat, tick, first, trig, sp_o, ps_o;
  wire [15:0] rxw, txw, dly;
  wire [4:0]  rx_hit = {sp_o, ps_o, trig, trig, trig};
  integer     err_count = 0;
  integer     compares  = 0;
  integer     cyc       = 0;
  msl_sync_link #(.TICK_PERIOD(20), .PING_PERIOD(50)) u_msl_sync_link (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .role_i(role), .direct_link_i(dlink),
    .ext_mode_i(xm), .own_time_src_i(tsrc), .rx_sig_det_i(sd), .rx_align_i(al),
    .rx_valid_i(vd), .rx_word_i(rxw), .chan_trig_i(ev[0]), .calc_trig_i(ev[1]),
    .man_trig_i(ev[2]), .rec_pause_i(ev[3]), .rec_stop_i(ev[4]), .rec_start_i(ev[5]),
    .tx_word_o(txw), .tx_en_o(tx_en), .led_sig_o(l_sig), .led_data_o(l_dat),
    .sample_tick_o(tick), .first_sample_o(first), .trig_o(trig), .rec_start_o(st_o),
    .rec_stop_o(sp_o), .rec_pause_o(ps_o), .time_src_o(ts_o), .cable_delay_o(dly),
    .ext_active_o());
  msl_peer_model u_msl_peer_model (
    .clk_i(clk_i), .tx_word_i(txw), .lvl_i(lvl), .lag_i(lag), .snd_i(snd),
    .snd_word_i(pk), .sig_o(sd), .align_o(al), .valid_o(vd), .word_o(rxw));
  always #50 clk_i = ~clk_i;
  task chk(input [16:0] s, input [16:0] e, input string m);
    begin
      compares = compares + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("CHECK FAILED t=%0t %s", $time, m);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      err_count = err_count + 1;
      test_done;
    end
  end
  task tk(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  // Peer word and local event for one cycle
  task pulse(input [15:0] w, input [5:0] m);
    begin
      @(posedge clk_i) begin pk <= w; snd <= 1'b1; ev <= m; end
      @(posedge clk_i) begin snd <= 1'b0; ev <= 6'h00; end
    end
  endtask
  task find_op(input [3:0] op);
    integer k;
    begin
      hit = 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        #1 if (txw[15:12] === op) hit = 1'b1;
        @(posedge clk_i);
      end
    end
  endtask
  task t_leds;
    integer i;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        @(posedge clk_i) lvl <= i[1:0];
        tk(4);
        #1 chk({l_sig, l_dat}, (i == 0) ? 2'h0 : (i == 1) ? 2'h2 : 2'h3, "leds");
      end
    end
  endtask
  task t_dly;
    begin
      @(posedge clk_i) lag <= 8'h14;
      tk(160);
      #1 d0 = dly;
      @(posedge clk_i) lag <= 8'h00;
      tk(160);
      #1 chk(d0 - dly, 16'h000A, "delay step");
      @(posedge clk_i) lvl <= 2'h0;
      tk(8);
      #1 chk(dly, 16'h0000, "delay down");
      @(posedge clk_i) lvl <= 2'h2;
      tk(8);
    end
  endtask
  task t_iso;
    begin
      @(posedge clk_i) role <= `MSL_ROLE_ISOLATED;
      tk(2);
      pulse(16'h0000, 6'h01);
      #1 chk({tx_en, txw}, 17'h00000, "iso tx");
      pulse({`MSL_MSG_TRIG, 12'h000}, 6'h00);
      tk(2);
      #1 chk(trig, 1'b0, "iso rx");
      @(posedge clk_i) role <= `MSL_ROLE_FOLLOWER;
      tk(3);
      #1 chk(ts_o, 1'b0, "follower time source");
      @(posedge clk_i) role <= `MSL_ROLE_LEADER;
      tk(3);
      #1 chk(ts_o, 1'b1, "leader time source");
      @(posedge clk_i) tsrc <= 1'b0;
      tk(2);
      #1 chk(ts_o, 1'b0, "leader source follows");
    end
  endtask
  // Start pends to the next tick; first sample waits out the cable delay of 1
  task t_start;
    begin
      @(posedge clk_i) begin dlink <= 1'b0; xm <= 1'b1; end
      tk(80);
      @(posedge tick);
      pulse(16'h0000, 6'h20);
      #1 chk(txw[15:12], `MSL_MSG_START, "tx start");
      tk(2);
      #1 chk(st_o, 1'b1, "local start");
      @(posedge tick);
      #1 chk(txw[15:12], `MSL_MSG_FIRST, "tx first");
      tk(2);
      #1 chk(first, 1'b1, "first sample");
    end
  endtask
  // Standard scheme passes channel triggers only
  task t_evt(input ex);
    integer i;
    begin
      @(posedge clk_i) dlink <= ex;
      for (i = 0; i < 5; i = i + 1) begin
        @(posedge tick);
        pulse(16'h0000, 6'h01 << i);
        find_op(OPS[i*4 +: 4]);
        chk(hit, ex | (i == 0), "tx event");
        pulse({OPS[i*4 +: 4], 12'h000}, 6'h00);
        tk(2);
        #1 chk(rx_hit[i], ex | (i == 0), "rx event");
      end
    end
  endtask
  initial begin
    tk(2);
    @(posedge clk_i) sys_rst_i <= 1'b0;
    #1 chk({tx_en, l_sig, l_dat, trig, first}, 5'h00, "reset");
    t_leds;
    t_dly;
    t_iso;
    t_evt(1'b0);
    t_evt(1'b1);
    t_start;
    test_done;
  end
endmodule // tb_msl_sync_link
